// ==== hdl/nvm_host_regs.vh ====
// Register offsets, fields and timing constants of the word alterable memory controller
`ifndef NVM_HOST_REGS_VH
`define NVM_HOST_REGS_VH
`define REG_CTRL        4'h0
`define REG_ADDR        4'h1
`define REG_WDATA       4'h2
`define REG_STATUS      4'h3
`define REG_RDATA       4'h4
`define CMD_READ        3'h1
`define CMD_WERASE      3'h2
`define CMD_BERASE      3'h3
`define CMD_WRITE       3'h4
`define CMD_UPDATE      3'h5
`define MODE_READ       2'b00
`define MODE_WRITE      2'b10
`define MODE_WERASE     2'b11
`define MODE_BERASE     2'b01
`define CLK_MHZ         25
`define T_SETUP_NS      100
`define T_HOLD_NS       350
`define T_ACCESS_NS     1000
`define T_CE_LOW_NS     1000
`define T_CE_HIGH_NS    750
`define T_DUMMY_HIGH_NS 1500
`define T_TRISTATE_NS   350
`define T_WE_NS         650
`define T_ERASE_MS      20
`define T_WRITE_MS      2
`endif

// ==== hdl/nvm_timer.v ====
// Down counter that times one interval of the strobe sequence
`timescale 1ns/1ps
module nvm_timer #(
  parameter W = 20
) (
  clk,
  resetn,
  load,
  count,
  done
);
  input          clk;
  input          resetn;
  input          load;
  input  [W-1:0] count;
  output         done;
  reg    [W-1:0] cnt_r;
  assign done = (cnt_r == {W{1'b0}});
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= {W{1'b0}};
    end else if (load) begin
      cnt_r <= count;
    end else if (cnt_r != {W{1'b0}}) begin
      cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
    end
  end
endmodule

// ==== hdl/nvm_sync.v ====
// Three stage synchroniser for the data nibble read back from the pins
`timescale 1ns/1ps
module nvm_sync #(
  parameter W = 4
) (
  clk,
  resetn,
  din,
  dout
);
  input          clk;
  input          resetn;
  input  [W-1:0] din;
  output [W-1:0] dout;
  reg    [W-1:0] s1_r;
  reg    [W-1:0] s2_r;
  reg    [W-1:0] s3_r;
  reg    [W-1:0] out_r;
  assign dout = out_r;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1_r  <= {W{1'b0}};
      s2_r  <= {W{1'b0}};
      s3_r  <= {W{1'b0}};
      out_r <= {W{1'b0}};
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        out_r <= s3_r;
      end
    end
  end
endmodule

// ==== hdl/nvm_host.v ====
// Controller that drives the word alterable memory through its strobes and pins
//
// Summary of operation
// - The select strobe stays high at least 700 ns between read cycles.
// - A location is erased before it is written; the update command does this, the write command writes without erasing.
// - Every erase ends with a dummy read preceded by at least 1500 ns of select strobe high.
// - During a dummy read the address lines are free and need not name the altered word.
// - Programming starts when the select strobe rises and the strobe stays high for the whole write time.
// - Every write ends with a dummy read and nothing else.
// - The data drivers are released before the dummy read that follows a write starts.
// - Separate data strobe kept so address and data could share one bus.
`timescale 1ns/1ps
`include "nvm_host_regs.vh"
module nvm_host #(
  parameter ERASE_CYC = `T_ERASE_MS * `CLK_MHZ * 1000,
  parameter WRITE_CYC = `T_WRITE_MS * `CLK_MHZ * 1000
) (
  clk,
  resetn,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rd,
  reg_rdata,
  word_address,
  mode_select_first,
  mode_select_second,
  select_n,
  data_strobe_n,
  data_nibble_in,
  data_nibble_out,
  data_nibble_oe_n
);
  input         clk;
  input         resetn;
  input  [3:0]  reg_addr;
  input  [31:0] reg_wdata;
  input         reg_wr;
  input         reg_rd;
  output [31:0] reg_rdata;
  output [9:0]  word_address;
  output        mode_select_first;
  output        mode_select_second;
  output        select_n;
  output        data_strobe_n;
  input  [3:0]  data_nibble_in;
  output [3:0]  data_nibble_out;
  output        data_nibble_oe_n;

  function [19:0] ns2cyc;
    input integer ns;
    integer       cyc;
    begin
      cyc    = (ns * `CLK_MHZ + 999) / 1000;
      ns2cyc = cyc[19:0];
    end
  endfunction

  localparam [19:0] C_SETUP = ns2cyc(`T_SETUP_NS);
  localparam [19:0] C_HOLD  = ns2cyc(`T_HOLD_NS);
  localparam [19:0] C_ACC   = ns2cyc(`T_ACCESS_NS + 160);
  localparam [19:0] C_CELOW = ns2cyc(`T_CE_LOW_NS);
  localparam [19:0] C_CEHI  = ns2cyc(`T_CE_HIGH_NS);
  localparam [19:0] C_DUMMY = ns2cyc(`T_DUMMY_HIGH_NS);
  localparam [19:0] C_TRIS  = ns2cyc(`T_TRISTATE_NS);
  localparam [19:0] C_WE    = ns2cyc(`T_WE_NS);
  localparam [19:0] C_ERASE = ERASE_CYC[19:0];
  localparam [19:0] C_WRITE = WRITE_CYC[19:0];

  localparam [3:0] S_IDLE  = 4'h0;
  localparam [3:0] S_SETUP = 4'h1;
  localparam [3:0] S_LOW   = 4'h2;
  localparam [3:0] S_WEHI  = 4'h3;
  localparam [3:0] S_HOLD  = 4'h4;
  localparam [3:0] S_ALTER = 4'h5;
  localparam [3:0] S_RELSE = 4'h6;
  localparam [3:0] S_GAP   = 4'h7;
  localparam [3:0] S_DSET  = 4'h8;
  localparam [3:0] S_DLOW  = 4'h9;
  localparam [3:0] S_DHOLD = 4'ha;
  localparam [3:0] S_REC   = 4'hb;

  reg  [3:0]  state_r;
  reg  [3:0]  state_nxt;
  reg  [1:0]  mode_r;
  reg  [2:0]  cmd_r;
  reg         busy_r;
  reg         done_r;
  reg         err_r;
  reg         upd_r;
  reg  [9:0]  addr_r;
  reg  [3:0]  wdata_r;
  reg  [3:0]  rdata_r;
  reg  [31:0] rdout_r;
  reg  [9:0]  pin_addr_r;
  reg         pin_m1_r;
  reg         pin_m2_r;
  reg         sel_n_r;
  reg         ds_n_r;
  reg  [3:0]  dout_r;
  reg         oe_n_r;
  reg         tload;
  reg  [19:0] tcount;
  wire        tdone;
  wire [3:0]  din_s;

  nvm_timer #(.W(20)) u_timer (
    .clk    (clk),
    .resetn (resetn),
    .load   (tload),
    .count  (tcount),
    .done   (tdone)
  );

  nvm_sync #(.W(4)) u_sync (
    .clk    (clk),
    .resetn (resetn),
    .din    (data_nibble_in),
    .dout   (din_s)
  );

  assign reg_rdata          = rdout_r;
  assign word_address       = pin_addr_r;
  assign mode_select_first  = pin_m1_r;
  assign mode_select_second = pin_m2_r;
  assign select_n           = sel_n_r;
  assign data_strobe_n      = ds_n_r;
  assign data_nibble_out    = dout_r;
  assign data_nibble_oe_n   = oe_n_r;

  wire start = reg_wr && (reg_addr == `REG_CTRL) && !busy_r;
  wire alter = (mode_r != `MODE_READ);

  // Sequencer next state and timer loads
  always @* begin
    state_nxt = state_r;
    tload     = 1'b0;
    tcount    = 20'h00000;
    case (state_r)
      S_IDLE: begin
        if (start && (reg_wdata[2:0] >= `CMD_READ) && (reg_wdata[2:0] <= `CMD_UPDATE)) begin
          state_nxt = S_SETUP;
          tload     = 1'b1;
          tcount    = C_SETUP;
        end
      end
      S_SETUP: begin
        if (tdone) begin
          state_nxt = S_LOW;
          tload     = 1'b1;
          tcount    = (mode_r == `MODE_WRITE) ? C_WE : ((mode_r == `MODE_READ) ? C_ACC : C_CELOW);
        end
      end
      S_LOW: begin
        if (tdone) begin
          state_nxt = (mode_r == `MODE_WRITE) ? S_WEHI : S_HOLD;
          tload     = 1'b1;
          tcount    = C_HOLD;
        end
      end
      S_WEHI: begin
        if (tdone) begin
          state_nxt = S_HOLD;
          tload     = 1'b1;
          tcount    = C_HOLD;
        end
      end
      S_HOLD: begin
        state_nxt = alter ? S_ALTER : S_REC;
        tload     = 1'b1;
        tcount    = alter ? ((mode_r == `MODE_WRITE) ? C_WRITE : C_ERASE) : C_CEHI;
      end
      S_ALTER: begin
        if (tdone) begin
          state_nxt = S_RELSE;
          tload     = 1'b1;
          tcount    = C_TRIS;
        end
      end
      S_RELSE: begin
        if (tdone) begin
          state_nxt = S_GAP;
          tload     = 1'b1;
          tcount    = C_DUMMY;
        end
      end
      S_GAP: begin
        if (tdone) begin
          state_nxt = S_DSET;
          tload     = 1'b1;
          tcount    = C_SETUP;
        end
      end
      S_DSET: begin
        if (tdone) begin
          state_nxt = S_DLOW;
          tload     = 1'b1;
          tcount    = C_CELOW;
        end
      end
      S_DLOW: begin
        if (tdone) begin
          state_nxt = S_DHOLD;
          tload     = 1'b1;
          tcount    = C_HOLD;
        end
      end
      S_DHOLD: begin
        if (tdone) begin
          state_nxt = S_REC;
          tload     = 1'b1;
          tcount    = C_CEHI;
        end
      end
      S_REC: begin
        if (tdone) begin
          state_nxt = (upd_r && (mode_r == `MODE_WERASE)) ? S_SETUP : S_IDLE;
          tload     = 1'b1;
          tcount    = C_SETUP;
        end
      end
      default: begin
        state_nxt = S_IDLE;
      end
    endcase
  end

  // Sequencer, pins and registers
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_r    <= S_IDLE;
      mode_r     <= `MODE_READ;
      cmd_r      <= 3'h0;
      busy_r     <= 1'b0;
      done_r     <= 1'b0;
      err_r      <= 1'b0;
      upd_r      <= 1'b0;
      addr_r     <= 10'h000;
      wdata_r    <= 4'h0;
      rdata_r    <= 4'h0;
      rdout_r    <= 32'h00000000;
      pin_addr_r <= 10'h000;
      pin_m1_r   <= 1'b0;
      pin_m2_r   <= 1'b0;
      sel_n_r    <= 1'b1;
      ds_n_r     <= 1'b1;
      dout_r     <= 4'h0;
      oe_n_r     <= 1'b1;
    end else begin
      state_r <= state_nxt;
      if (reg_wr && (reg_addr == `REG_ADDR) && !busy_r) begin
        addr_r <= reg_wdata[9:0];
      end
      if (reg_wr && (reg_addr == `REG_WDATA) && !busy_r) begin
        wdata_r <= reg_wdata[3:0];
      end
      if (reg_wr && (reg_addr == `REG_STATUS)) begin
        done_r <= 1'b0;
        err_r  <= 1'b0;
      end
      if (reg_wr && (reg_addr == `REG_CTRL) && busy_r) begin
        err_r <= 1'b1;
      end
      if (state_r == S_IDLE && state_nxt == S_SETUP) begin
        busy_r <= 1'b1;
        cmd_r  <= reg_wdata[2:0];
        upd_r  <= (reg_wdata[2:0] == `CMD_UPDATE);
        if (reg_wdata[2:0] == `CMD_READ) begin
          mode_r <= `MODE_READ;
        end else if (reg_wdata[2:0] == `CMD_BERASE) begin
          mode_r <= `MODE_BERASE;
        end else begin
          mode_r <= (reg_wdata[2:0] == `CMD_WRITE) ? `MODE_WRITE : `MODE_WERASE;
        end
      end else if (start) begin
        err_r <= 1'b1;
      end
      if (state_r == S_REC && state_nxt == S_SETUP) begin
        mode_r <= `MODE_WRITE;
      end
      if (state_r == S_REC && state_nxt == S_IDLE) begin
        busy_r <= 1'b0;
        done_r <= 1'b1;
        oe_n_r <= 1'b1;
      end
      // Address, mode and write data set up ahead of the falling select strobe
      if (state_r == S_SETUP) begin
        pin_addr_r <= addr_r;
        pin_m1_r   <= mode_r[1];
        pin_m2_r   <= mode_r[0];
      end else if (state_r == S_GAP) begin
        pin_m1_r <= 1'b0;
        pin_m2_r <= 1'b0;
      end
      if (state_r == S_SETUP && mode_r == `MODE_WRITE) begin
        dout_r <= wdata_r;
        oe_n_r <= 1'b0;
      end
      if (state_nxt == S_LOW || state_nxt == S_DLOW) begin
        sel_n_r <= 1'b0;
      end
      if (state_r == S_SETUP || state_r == S_LOW) begin
        ds_n_r <= !(state_nxt == S_LOW && mode_r == `MODE_WRITE);
      end
      if (state_nxt == S_HOLD && state_r == S_LOW && mode_r == `MODE_READ) begin
        rdata_r <= din_s;
      end
      if ((state_r == S_HOLD) || (state_r == S_DHOLD && tdone)) begin
        sel_n_r <= 1'b1;
      end
      if (state_r == S_ALTER && tdone) begin
        oe_n_r <= 1'b1;
      end
      rdout_r <= 32'h00000000;
      if (reg_rd) begin
        if (reg_addr == `REG_CTRL) begin
          rdout_r <= {29'h0, cmd_r};
        end else if (reg_addr == `REG_ADDR) begin
          rdout_r <= {22'h0, addr_r};
        end else if (reg_addr == `REG_WDATA) begin
          rdout_r <= {28'h0, wdata_r};
        end else if (reg_addr == `REG_STATUS) begin
          rdout_r <= {25'h0, state_r, err_r, done_r, busy_r};
        end else if (reg_addr == `REG_RDATA) begin
          rdout_r <= {28'h0, rdata_r};
        end
      end
    end
  end
endmodule

// ==== verification/nvm_host_props.sv ====
// Pin protocol checker for the memory controller
`timescale 1ns/1ps
`include "nvm_host_regs.vh"
module nvm_host_props #(
  parameter int ERASE_CYC = 500000,
  parameter int WRITE_CYC = 50000
) (
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic [9:0] word_address,
  input wire logic       mode_select_first,
  input wire logic       mode_select_second,
  input wire logic       select_n,
  input wire logic       data_strobe_n,
  input wire logic [3:0] data_nibble_out,
  input wire logic       data_nibble_oe_n
);
  logic [19:0] hi_cnt;
  logic [10:0] lo_cnt;
  logic [1:0]  last_mode_r;
  wire  [1:0]  mode = {mode_select_first, mode_select_second};
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hi_cnt <= '1;
      lo_cnt <= '0;
      last_mode_r <= `MODE_READ;
    end else begin
      hi_cnt <= !select_n ? 20'h0 : (&hi_cnt) ? hi_cnt : hi_cnt + 20'h1;
      lo_cnt <= select_n ? 11'h0 : lo_cnt + 11'h1;
      if (!select_n && lo_cnt == 11'h0) last_mode_r <= mode;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_addr_setup;
    $fell(select_n) |-> $stable(word_address) && $stable(mode);
  endproperty
  a_addr_setup: assert property (p_addr_setup) else $error("address or mode moved at select fall");
  property p_read_gap;
    $fell(select_n) |-> hi_cnt >= 20'd18;
  endproperty
  a_read_gap: assert property (p_read_gap) else $error("select high time too short");
  property p_alter_wait;
    $fell(select_n) && last_mode_r != `MODE_READ |->
      hi_cnt >= 20'd38 && hi_cnt >= (last_mode_r == `MODE_WRITE ? WRITE_CYC : ERASE_CYC);
  endproperty
  a_alter_wait: assert property (p_alter_wait) else $error("alteration wait cut short");
  property p_dummy_mode;
    $fell(select_n) && last_mode_r != `MODE_READ |-> mode == `MODE_READ;
  endproperty
  a_dummy_mode: assert property (p_dummy_mode) else $error("alteration not ended by a read");
  property p_bus_release;
    !select_n && mode == `MODE_READ |-> data_nibble_oe_n;
  endproperty
  a_bus_release: assert property (p_bus_release) else $error("data driven during read");
  property p_strobe_window;
    !data_strobe_n |-> !select_n && mode == `MODE_WRITE;
  endproperty
  a_strobe_window: assert property (p_strobe_window) else $error("data strobe outside write");
  property p_strobe_data;
    $rose(data_strobe_n) |-> (!data_nibble_oe_n && $stable(data_nibble_out)) [*3];
  endproperty
  a_strobe_data: assert property (p_strobe_data) else $error("data not held after strobe");
  property p_low_width;
    $rose(select_n) |-> lo_cnt >= 11'd25 && lo_cnt <= 11'd1250;
  endproperty
  a_low_width: assert property (p_low_width) else $error("select pulse width out of range");
  c_berase: cover property ($fell(select_n) && mode == `MODE_BERASE);
  c_werase: cover property ($fell(select_n) && mode == `MODE_WERASE);
  c_write: cover property ($rose(data_strobe_n));
  c_read: cover property ($fell(select_n) && mode == `MODE_READ);
endmodule
bind nvm_host nvm_host_props #(.ERASE_CYC(ERASE_CYC), .WRITE_CYC(WRITE_CYC)) u_props (
  .clk(clk), .resetn(resetn), .word_address(word_address), .mode_select_first(mode_select_first),
  .mode_select_second(mode_select_second), .select_n(select_n), .data_strobe_n(data_strobe_n),
  .data_nibble_out(data_nibble_out), .data_nibble_oe_n(data_nibble_oe_n));

// ==== verification/nvm_mem_model.sv ====
// Behavioural word alterable memory on the far side of the pins
`timescale 1ns/1ps
`include "nvm_host_regs.vh"
module nvm_mem_model #(
  parameter int ACC_NS   = 900,
  parameter int ERASE_NS = 4000,
  parameter int WRITE_NS = 2000
) (
  input  wire logic [9:0] word_address,
  input  wire logic       mode_select_first,
  input  wire logic       mode_select_second,
  input  wire logic       select_n,
  input  wire logic       data_strobe_n,
  input  wire logic [3:0] pin,
  output logic      [3:0] bus_out,
  output logic            bus_en
);
  logic [3:0] mem [0:1023];
  logic [9:0] a_r, pa_r;
  logic [1:0] m_r, pm_r;
  logic [3:0] d_r;
  logic       pend_r, dummy;
  time        t0;
  initial begin
    bus_out = 4'h5;
    bus_en = 1'b0;
    pend_r = 1'b0;
    foreach (mem[i]) mem[i] = 4'h5;
  end
  always @(negedge select_n) begin
    a_r = word_address;
    m_r = {mode_select_first, mode_select_second};
    if (m_r == `MODE_READ) begin
      dummy = pend_r;
      pend_r = 1'b0;
      if (dummy && $time - t0 < (pm_r == `MODE_WRITE ? WRITE_NS : ERASE_NS)) mem[pa_r] = 4'hx;
      else if (dummy && pm_r == `MODE_BERASE) foreach (mem[i]) mem[i] = 4'hf;
      else if (dummy && pm_r == `MODE_WERASE) mem[pa_r] = 4'hf;
      else if (dummy) mem[pa_r] = mem[pa_r] & d_r;
      #(ACC_NS);
      bus_en = !select_n;
      bus_out = dummy ? 4'($urandom) : mem[a_r];
    end
  end
  always @(posedge select_n) begin
    bus_en <= #50 1'b0;
    bus_out <= #50 ~bus_out;
    if (m_r != `MODE_READ) begin
      pend_r = 1'b1;
      pm_r = m_r;
      pa_r = a_r;
      t0 = $time;
    end
  end
  always @(posedge data_strobe_n) begin
    if (!select_n && m_r == `MODE_WRITE) d_r = pin;
  end
endmodule

// ==== verification/testbench.sv ====
// Self-checking bench for the memory controller and memory model
`timescale 1ns/1ps
`include "nvm_host_regs.vh"
module testbench;
  logic        clk, resetn, reg_wr, reg_rd, rd_d;
  logic [3:0]  reg_addr, d, last;
  logic [31:0] reg_wdata, got;
  logic [63:0] e;
  logic [9:0]  a;
  logic [3:0]  shadow [0:1023];
  logic [63:0] exp_q[$];
  wire  [31:0] reg_rdata;
  wire  [9:0]  word_address;
  wire         msf, mss, select_n, data_strobe_n, oe_n, m_en;
  wire  [3:0]  dout, pin, m_out;
  int          n_errors = 0;
  int          n_checks = 0;
  int          i;
  assign pin = oe_n ? m_out : (m_en ? 4'hx : dout);
  nvm_host #(.ERASE_CYC(200), .WRITE_CYC(100)) dut (
    .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .word_address(word_address), .mode_select_first(msf),
    .mode_select_second(mss), .select_n(select_n), .data_strobe_n(data_strobe_n),
    .data_nibble_in(pin), .data_nibble_out(dout), .data_nibble_oe_n(oe_n));
  nvm_mem_model mdl (
    .word_address(word_address), .mode_select_first(msf), .mode_select_second(mss),
    .select_n(select_n), .data_strobe_n(data_strobe_n), .pin(pin), .bus_out(m_out), .bus_en(m_en));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic end_sim;
    if (n_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: read %h expected %h", $time, seen, exp);
    end
  endtask
  always @(posedge clk) begin
    if (rd_d) begin
      e = exp_q.pop_front();
      check(reg_rdata & e[63:32], e[31:0]);
    end
    rd_d <= reg_rd;
  end
  task automatic wr(input logic [3:0] ad, input logic [31:0] v);
    reg_addr <= ad;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [3:0] ad, input logic [31:0] m, input logic [31:0] v);
    exp_q.push_back({m, v});
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    got = reg_rdata;
    @(posedge clk);
  endtask
  task automatic wait_idle;
    for (int k = 0; k < 3000; k++) begin
      rd(`REG_STATUS, 32'h0, 32'h0);
      if (got[0] === 1'b0) return;
    end
    n_errors++;
    end_sim();
  endtask
  task automatic op(input logic [2:0] c, input logic [9:0] ad, input logic [3:0] v);
    wr(`REG_ADDR, {22'h0, ad});
    wr(`REG_WDATA, {28'h0, v});
    wr(`REG_CTRL, {29'h0, c});
    wait_idle();
    rd(`REG_STATUS, 32'h6, 32'h2);
    wr(`REG_STATUS, 32'h0);
    if (c == `CMD_BERASE) foreach (shadow[j]) shadow[j] = 4'hf;
    if (c == `CMD_WERASE) shadow[ad] = 4'hf;
    if (c == `CMD_WRITE) shadow[ad] = shadow[ad] & v;
    if (c == `CMD_UPDATE) shadow[ad] = v;
    if (c == `CMD_READ) last = shadow[ad];
    rd(`REG_RDATA, 32'hf, {28'h0, last});
  endtask
  initial begin
    resetn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    rd_d = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    last = 4'h0;
    void'($urandom(32'h94b04d0a));
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rd(`REG_STATUS, 32'h7, 32'h0);
    rd(4'hf, 32'hffffffff, 32'h0);
    op(`CMD_BERASE, 10'h0, 4'h0);
    for (i = 0; i < 4; i++) begin
      a = (i == 0) ? 10'h3ff : 10'($urandom);
      op(`CMD_UPDATE, a, 4'($urandom));
      op(`CMD_READ, a, 4'h0);
      op(`CMD_READ, a ^ 10'h1, 4'h0);
    end
    op(`CMD_WERASE, a, 4'h0);
    op(`CMD_READ, a, 4'h0);
    op(`CMD_WRITE, a, 4'h9);
    op(`CMD_READ, a, 4'h0);
    wr(`REG_CTRL, {29'h0, `CMD_WERASE});
    wr(`REG_CTRL, {29'h0, `CMD_READ});
    rd(`REG_STATUS, 32'h5, 32'h5);
    wait_idle();
    rd(`REG_STATUS, 32'h6, 32'h6);
    wr(`REG_STATUS, 32'h0);
    wr(`REG_CTRL, 32'h7);
    rd(`REG_STATUS, 32'h7, 32'h4);
    wr(`REG_STATUS, 32'h0);
    shadow[a] = 4'hf;
    op(`CMD_READ, a, 4'h0);
    end_sim();
  end
endmodule
